/* logic/core_regs_defines.vh */
// constants for the core register set and memory map
// assumes inclusion by bare name from design files under logic/
`ifndef CORE_REGS_DEFINES_VH
`define CORE_REGS_DEFINES_VH

// direct addresses of the core special registers
`define ADDR_ACC 8'hE0
`define ADDR_B 8'hF0
`define ADDR_STATUS 8'hD0
`define ADDR_SP 8'h81
`define ADDR_DP_LOW 8'h82
`define ADDR_DP_HIGH 8'h83
`define ADDR_DDC_PTR 8'h95
`define ADDR_DDC_BUF 8'h96
`define ADDR_DDC_CTRL 8'h97

// status word field positions
`define SW_CY 7
`define SW_AC 6
`define SW_F0 5
`define SW_BSH 4
`define SW_BSL 3
`define SW_OV 2
`define SW_F1 1
`define SW_P 0

// reset values
`define RST_SP 8'h07
`define RST_PC 16'h0000
`define RST_ZERO 8'h00
`define RST_DDC_EN 1'b1

// memory map
`define SFR_BASE 8'h80
`define BIT_RAM_BASE 8'h20
`define DDC_PAGE 8'hFF
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008

// ALU operation codes
`define OP_NONE 3'h0
`define OP_ADD 3'h1
`define OP_SUB 3'h2
`define OP_ROT 3'h3
`define OP_MUL 3'h4
`define OP_DIV 3'h5
`define OP_BIT 3'h6
`define OP_CLEAR_OVERFLOW_INSTR 3'h7

`endif

/* logic/core_regs.v */
// architectural register set, internal RAM and memory map decode of the core
// assumes an instruction sequencer drives the request ports below; one clock
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_defines.vh"

module core_regs (
	input wire CLK,
	input wire RST_B,
	// program counter and stack
	input wire PC_LOAD,
	input wire [15:0] PC_VALUE,
	input wire PC_INC,
	input wire INT_TAKE,
	input wire [2:0] INT_NUM,
	input wire PUSH,
	input wire POP,
	input wire [7:0] PUSH_DATA,
	// internal data access
	input wire IRAM_WE,
	input wire IRAM_INDIRECT,
	input wire IRAM_REG,
	input wire [2:0] IRAM_REGNUM,
	input wire [7:0] IRAM_ADDR,
	input wire [7:0] IRAM_WDATA,
	input wire BIT_WE,
	input wire [7:0] BIT_ADDR,
	input wire BIT_WDATA,
	// alu results
	input wire [2:0] ALU_OP,
	input wire [7:0] ALU_SRC,
	input wire ALU_CIN,
	input wire ALU_ROT_CARRY,
	// data pointer and external data space
	input wire DP_INC,
	input wire XMOVE,
	input wire XMOVE_WE,
	input wire XMOVE_VIA_DP,
	input wire [7:0] XMOVE_PTR8,
	input wire [7:0] XMOVE_WDATA,
	// program and flash access
	input wire CODE_FETCH,
	input wire FLASH_WE_REQ,
	input wire FLASH_PROG,
	output wire [15:0] PC,
	output wire [15:0] CODE_ADDR,
	output wire [7:0] STACK_POINTER,
	output reg [7:0] IRAM_RDATA,
	output reg BIT_RDATA,
	output wire [7:0] POP_DATA,
	output wire [7:0] ACCUMULATOR,
	output wire [7:0] B_OPERAND,
	output wire [7:0] STATUS_WORD,
	output wire [15:0] DATA_POINTER,
	output wire [15:0] XDATA_ADDR,
	output wire XDATA_EXT_SEL,
	output reg [7:0] XDATA_RDATA,
	output wire FLASH_WE
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	reg [7:0] iram_ff [0:255];
	reg [7:0] ddc_ram_ff [0:255];
	reg [15:0] pc_ff;
	reg [7:0] sp_ff;
	reg [7:0] acc_ff;
	reg [7:0] b_ff;
	reg [7:0] sw_ff;
	reg [7:0] dpl_ff;
	reg [7:0] dph_ff;
	reg [7:0] ddc_ptr_ff;
	reg [7:0] ddc_buf_ff;
	reg ddc_en_ff;
	integer i;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire [1:0] bank = {sw_ff[`SW_BSH], sw_ff[`SW_BSL]};
	wire [7:0] reg_addr = {3'b000, bank, IRAM_REGNUM};
	// indirect access always lands in RAM, upper half too
	wire [7:0] eff_addr = IRAM_REG ? reg_addr : IRAM_ADDR;
	wire is_sfr = !IRAM_REG && !IRAM_INDIRECT && eff_addr[7];
	wire [7:0] sp_inc = sp_ff + 8'h01;
	wire [15:0] data_pointer = {dph_ff, dpl_ff};
	assign XDATA_ADDR = XMOVE_VIA_DP ? data_pointer : {`DDC_PAGE, XMOVE_PTR8};
	wire ddc_hit = ddc_en_ff && (XDATA_ADDR[15:8] == `DDC_PAGE);
	assign XDATA_EXT_SEL = XMOVE && !ddc_hit;
	assign FLASH_WE = FLASH_WE_REQ && FLASH_PROG;
	assign CODE_ADDR = CODE_FETCH ? pc_ff : data_pointer;

	// bit address: below 80h maps into RAM 20h-2Fh, else SPECIAL_REGISTER_SPACE ending 0h/8h
	wire [7:0] bit_byte = BIT_ADDR[7] ? {BIT_ADDR[7:3], 3'b000} :
		(`BIT_RAM_BASE + {4'h0, BIT_ADDR[6:3]});
	wire [2:0] bit_pos = BIT_ADDR[2:0];

	// ----------------------------------------------------------------
	// alu flag computation
	// ----------------------------------------------------------------
	wire [8:0] add_full = {1'b0, acc_ff} + {1'b0, ALU_SRC} + {8'h00, ALU_CIN};
	wire [4:0] add_low = {1'b0, acc_ff[3:0]} + {1'b0, ALU_SRC[3:0]} + {4'h0, ALU_CIN};
	wire [8:0] sub_full = {1'b0, acc_ff} - {1'b0, ALU_SRC} - {8'h00, ALU_CIN};
	wire [4:0] sub_low = {1'b0, acc_ff[3:0]} - {1'b0, ALU_SRC[3:0]} - {4'h0, ALU_CIN};
	wire add_ov = (acc_ff[7] == ALU_SRC[7]) && (add_full[7] != acc_ff[7]);
	wire sub_ov = (acc_ff[7] != ALU_SRC[7]) && (sub_full[7] != acc_ff[7]);
	wire [15:0] product = acc_ff * b_ff;
	wire [7:0] quot = (b_ff == 8'h00) ? 8'hFF : acc_ff / b_ff;
	wire [7:0] rem = (b_ff == 8'h00) ? 8'h00 : acc_ff % b_ff;

	// ----------------------------------------------------------------
	// read paths
	// ----------------------------------------------------------------
	reg [7:0] sfr_rd;
	always @* begin
		case (eff_addr)
			`ADDR_ACC: sfr_rd = acc_ff;
			`ADDR_B: sfr_rd = b_ff;
			`ADDR_STATUS: sfr_rd = STATUS_WORD;
			`ADDR_SP: sfr_rd = sp_ff;
			`ADDR_DP_LOW: sfr_rd = dpl_ff;
			`ADDR_DP_HIGH: sfr_rd = dph_ff;
			`ADDR_DDC_PTR: sfr_rd = ddc_ptr_ff;
			`ADDR_DDC_BUF: sfr_rd = ddc_buf_ff;
			`ADDR_DDC_CTRL: sfr_rd = {7'h00, ddc_en_ff};
			default: sfr_rd = 8'h00;
		endcase
	end

	reg [7:0] bit_src;
	always @* begin
		if (BIT_ADDR[7]) begin
			case (bit_byte)
				`ADDR_ACC: bit_src = acc_ff;
				`ADDR_B: bit_src = b_ff;
				`ADDR_STATUS: bit_src = STATUS_WORD;
				default: bit_src = 8'h00;
			endcase
		end else begin
			bit_src = iram_ff[bit_byte];
		end
	end

	// registered read data so outputs come from flip-flops
	always @(posedge CLK) begin
		if (!RST_B) begin
			IRAM_RDATA <= `RST_ZERO;
			BIT_RDATA <= 1'b0;
			XDATA_RDATA <= `RST_ZERO;
		end else begin
			IRAM_RDATA <= is_sfr ? sfr_rd : iram_ff[eff_addr];
			BIT_RDATA <= bit_src[bit_pos];
			XDATA_RDATA <= ddc_hit ? ddc_ram_ff[XDATA_ADDR[7:0]] : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// program counter and stack pointer
	// ----------------------------------------------------------------
	always @(posedge CLK) begin
		if (!RST_B) begin
			pc_ff <= `RST_PC;
			sp_ff <= `RST_SP;
		end else begin
			if (INT_TAKE)
				pc_ff <= `VEC_BASE + {10'h000, INT_NUM, 3'b000};
			else if (PC_LOAD)
				pc_ff <= PC_VALUE;
			else if (PC_INC)
				pc_ff <= pc_ff + 16'h0001;
			if (PUSH)
				sp_ff <= sp_inc;
			else if (POP)
				sp_ff <= sp_ff - 8'h01;
			else if (IRAM_WE && is_sfr && eff_addr == `ADDR_SP)
				sp_ff <= IRAM_WDATA;
		end
	end

	assign POP_DATA = iram_ff[sp_ff];

	// ----------------------------------------------------------------
	// internal RAM: stack writes at the pre-incremented pointer
	// ----------------------------------------------------------------
	always @(posedge CLK) begin
		if (!RST_B) begin
			for (i = 0; i < 256; i = i + 1)
				iram_ff[i] <= `RST_ZERO;
		end else begin
			if (PUSH)
				iram_ff[sp_inc] <= PUSH_DATA;
			else if (IRAM_WE && !is_sfr)
				iram_ff[eff_addr] <= IRAM_WDATA;
			else if (BIT_WE && !BIT_ADDR[7])
				iram_ff[bit_byte][bit_pos] <= BIT_WDATA;
		end
	end

	// ----------------------------------------------------------------
	// accumulator, B, status word
	// ----------------------------------------------------------------
	always @(posedge CLK) begin
		if (!RST_B) begin
			acc_ff <= `RST_ZERO;
			b_ff <= `RST_ZERO;
			sw_ff <= `RST_ZERO;
		end else begin
			case (ALU_OP)
				`OP_ADD: begin
					acc_ff <= add_full[7:0];
					sw_ff[`SW_CY] <= add_full[8];
					sw_ff[`SW_AC] <= add_low[4];
					sw_ff[`SW_OV] <= add_ov;
				end
				`OP_SUB: begin
					// both carries hold the inverted borrow after a subtraction
					acc_ff <= sub_full[7:0];
					sw_ff[`SW_CY] <= ~sub_full[8];
					sw_ff[`SW_AC] <= ~sub_low[4];
					sw_ff[`SW_OV] <= sub_ov;
				end
				`OP_ROT: begin
					acc_ff <= ALU_SRC;
					sw_ff[`SW_CY] <= ALU_ROT_CARRY;
				end
				`OP_MUL: begin
					acc_ff <= product[7:0];
					b_ff <= product[15:8];
					sw_ff[`SW_CY] <= 1'b0;
					sw_ff[`SW_OV] <= (product[15:8] != 8'h00);
				end
				`OP_DIV: begin
					acc_ff <= quot;
					b_ff <= rem;
					sw_ff[`SW_CY] <= 1'b0;
					sw_ff[`SW_OV] <= (b_ff == 8'h00);
				end
				`OP_BIT: sw_ff[`SW_OV] <= ALU_SRC[6];
				`OP_CLEAR_OVERFLOW_INSTR: sw_ff[`SW_OV] <= 1'b0;
				default: begin
					if (IRAM_WE && is_sfr) begin
						if (eff_addr == `ADDR_ACC)
							acc_ff <= IRAM_WDATA;
						if (eff_addr == `ADDR_B)
							b_ff <= IRAM_WDATA;
						if (eff_addr == `ADDR_STATUS)
							sw_ff <= {IRAM_WDATA[7:1], 1'b0};
					end else if (BIT_WE && BIT_ADDR[7]) begin
						if (bit_byte == `ADDR_ACC)
							acc_ff[bit_pos] <= BIT_WDATA;
						if (bit_byte == `ADDR_B)
							b_ff[bit_pos] <= BIT_WDATA;
						if (bit_byte == `ADDR_STATUS)
							sw_ff[bit_pos] <= BIT_WDATA;
					end
				end
			endcase
		end
	end

	// parity is live, never stored
	assign STATUS_WORD = {sw_ff[7:1], ~(^acc_ff)};

	// ----------------------------------------------------------------
	// data pointer and display RAM
	// ----------------------------------------------------------------
	wire sfr_wr = IRAM_WE && is_sfr;
	wire ptr_access = !IRAM_REG && !IRAM_INDIRECT && eff_addr == `ADDR_DDC_BUF;
	wire buf_wr = sfr_wr && ptr_access;
	wire buf_rd = !IRAM_WE && ptr_access && IRAM_REG == 1'b0 && ddc_en_ff && XMOVE == 1'b0 &&
		IRAM_ADDR == `ADDR_DDC_BUF;

	always @(posedge CLK) begin
		if (!RST_B) begin
			dpl_ff <= `RST_ZERO;
			dph_ff <= `RST_ZERO;
			ddc_ptr_ff <= `RST_ZERO;
			ddc_buf_ff <= `RST_ZERO;
			ddc_en_ff <= `RST_DDC_EN;
		end else begin
			if (DP_INC)
				{dph_ff, dpl_ff} <= data_pointer + 16'h0001;
			else if (sfr_wr && eff_addr == `ADDR_DP_LOW)
				dpl_ff <= IRAM_WDATA;
			else if (sfr_wr && eff_addr == `ADDR_DP_HIGH)
				dph_ff <= IRAM_WDATA;
			if (sfr_wr && eff_addr == `ADDR_DDC_CTRL)
				ddc_en_ff <= IRAM_WDATA[0];
			// buffer access moves the pointer on for bulk transfers
			if (sfr_wr && eff_addr == `ADDR_DDC_PTR)
				ddc_ptr_ff <= IRAM_WDATA;
			else if (buf_wr || buf_rd)
				ddc_ptr_ff <= ddc_ptr_ff + 8'h01;
			if (buf_wr)
				ddc_buf_ff <= IRAM_WDATA;
			else if (buf_rd)
				ddc_buf_ff <= ddc_ram_ff[ddc_ptr_ff + 8'h01];
			else if (sfr_wr && eff_addr == `ADDR_DDC_PTR)
				ddc_buf_ff <= ddc_ram_ff[IRAM_WDATA];
		end
	end

	// display RAM contents are not reset; software owns them
	always @(posedge CLK) begin
		if (XMOVE && XMOVE_WE && ddc_hit)
			ddc_ram_ff[XDATA_ADDR[7:0]] <= XMOVE_WDATA;
		else if (buf_wr && ddc_en_ff)
			ddc_ram_ff[ddc_ptr_ff] <= IRAM_WDATA;
	end

	assign PC = pc_ff;
	assign STACK_POINTER = sp_ff;
	assign ACCUMULATOR = acc_ff;
	assign B_OPERAND = b_ff;
	assign DATA_POINTER = data_pointer;

endmodule // core_regs

`default_nettype wire

/* tb/core_regs_chk.sv */
// concurrent checks on the top ports of the core register block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module core_regs_chk (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic INT_TAKE,
	input wire logic [2:0] INT_NUM,
	input wire logic PUSH,
	input wire logic [2:0] ALU_OP,
	input wire logic [7:0] ALU_SRC,
	input wire logic XMOVE,
	input wire logic XMOVE_VIA_DP,
	input wire logic [7:0] XMOVE_PTR8,
	input wire logic [15:0] PC,
	input wire logic [7:0] STACK_POINTER,
	input wire logic [7:0] ACCUMULATOR,
	input wire logic [7:0] STATUS_WORD,
	input wire logic [15:0] XDATA_ADDR,
	input wire logic XDATA_EXT_SEL
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	reset_vals_a: assert property ($rose(RST_B) |-> PC == 16'h0000 && STACK_POINTER == 8'h07)
		else $error("bad reset values");
	push_pre_a: assert property (PUSH |=> STACK_POINTER == $past(STACK_POINTER) + 8'h01)
		else $error("push slot wrong");
	int_vector_a: assert property (INT_TAKE |=> PC == 16'h0003 + {10'h000, $past(INT_NUM), 3'h0})
		else $error("vector wrong");
	parity_flag_a: assert property (STATUS_WORD[0] == ~^ACCUMULATOR)
		else $error("parity wrong");
	ov_clear_a: assert property (ALU_OP == 3'h7 |=> !STATUS_WORD[2])
		else $error("overflow not cleared");
	bit_test_a: assert property (ALU_OP == 3'h6 |=> STATUS_WORD[2] == $past(ALU_SRC[6]))
		else $error("bit test copy wrong");
	page_addr_a: assert property (XMOVE && !XMOVE_VIA_DP |-> XDATA_ADDR == {8'hFF, XMOVE_PTR8})
		else $error("page address wrong");
	ext_sel_a: assert property (XMOVE && XDATA_ADDR[15:8] != 8'hFF |-> XDATA_EXT_SEL)
		else $error("external select missing");
	cover property (PUSH ##1 PUSH);
	cover property (INT_TAKE && INT_NUM == 3'h7);
	cover property (XMOVE && !XDATA_EXT_SEL);
endmodule // core_regs_chk
bind core_regs core_regs_chk u_chk (.CLK(CLK), .RST_B(RST_B), .INT_TAKE(INT_TAKE), .INT_NUM(INT_NUM),
	.PUSH(PUSH), .ALU_OP(ALU_OP), .ALU_SRC(ALU_SRC), .XMOVE(XMOVE), .XMOVE_VIA_DP(XMOVE_VIA_DP),
	.XMOVE_PTR8(XMOVE_PTR8), .PC(PC), .STACK_POINTER(STACK_POINTER), .ACCUMULATOR(ACCUMULATOR),
	.STATUS_WORD(STATUS_WORD), .XDATA_ADDR(XDATA_ADDR), .XDATA_EXT_SEL(XDATA_EXT_SEL));
`default_nettype wire

/* tb/ext_mem_model.sv */
// far-side model: external data memory and program flash write counters
// assumes writes are sampled on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input wire logic clk,
	input wire logic sel,
	input wire logic we,
	input wire logic fl_we,
	output logic [7:0] n_wr_ff,
	output logic [7:0] n_fl_ff
);
	// counts only: the block has no port for far-side read data
	initial {n_wr_ff, n_fl_ff} = 16'h0000;
	always @(posedge clk) begin
		if (sel && we) n_wr_ff <= n_wr_ff + 8'h01;
		if (fl_we) n_fl_ff <= n_fl_ff + 8'h01;
	end
endmodule // ext_mem_model
`default_nettype wire

/* tb/core_regs_tb.sv */
// self-checking bench for the core register block
// assumes the far-side model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module core_regs_tb;
	reg CLK = 1'b0;
	reg RST_B, PC_LOAD, PC_INC, INT_TAKE, PUSH, POP, IRAM_WE, IRAM_INDIRECT, IRAM_REG, BIT_WE, BIT_WDATA, ALU_CIN;
	reg ALU_ROT_CARRY, DP_INC, XMOVE, XMOVE_WE, XMOVE_VIA_DP, CODE_FETCH, FLASH_WE_REQ, FLASH_PROG;
	reg [15:0] PC_VALUE;
	reg [2:0] INT_NUM, IRAM_REGNUM, ALU_OP;
	reg [7:0] PUSH_DATA, IRAM_ADDR, IRAM_WDATA, BIT_ADDR, ALU_SRC, XMOVE_PTR8, XMOVE_WDATA;
	wire [15:0] PC, CODE_ADDR, DATA_POINTER, XDATA_ADDR;
	wire [7:0] STACK_POINTER, IRAM_RDATA, POP_DATA, ACCUMULATOR, B_OPERAND, STATUS_WORD, XDATA_RDATA, n_wr, n_fl;
	wire XDATA_EXT_SEL, FLASH_WE, BIT_RDATA;
	integer n_fail = 0, compares = 0, cyc = 0, i;
	core_regs DUT (.CLK(CLK), .RST_B(RST_B), .PC_LOAD(PC_LOAD), .PC_VALUE(PC_VALUE), .PC_INC(PC_INC),
		.INT_TAKE(INT_TAKE), .INT_NUM(INT_NUM), .PUSH(PUSH), .POP(POP), .PUSH_DATA(PUSH_DATA), .IRAM_WE(IRAM_WE),
		.IRAM_INDIRECT(IRAM_INDIRECT), .IRAM_REG(IRAM_REG), .IRAM_REGNUM(IRAM_REGNUM), .IRAM_ADDR(IRAM_ADDR),
		.IRAM_WDATA(IRAM_WDATA), .BIT_WE(BIT_WE), .BIT_ADDR(BIT_ADDR), .BIT_WDATA(BIT_WDATA), .ALU_OP(ALU_OP),
		.ALU_SRC(ALU_SRC), .ALU_CIN(ALU_CIN), .ALU_ROT_CARRY(ALU_ROT_CARRY), .DP_INC(DP_INC), .XMOVE(XMOVE),
		.XMOVE_WE(XMOVE_WE), .XMOVE_VIA_DP(XMOVE_VIA_DP), .XMOVE_PTR8(XMOVE_PTR8), .XMOVE_WDATA(XMOVE_WDATA),
		.CODE_FETCH(CODE_FETCH), .FLASH_WE_REQ(FLASH_WE_REQ), .FLASH_PROG(FLASH_PROG), .PC(PC),
		.CODE_ADDR(CODE_ADDR), .STACK_POINTER(STACK_POINTER), .IRAM_RDATA(IRAM_RDATA), .BIT_RDATA(BIT_RDATA),
		.POP_DATA(POP_DATA), .ACCUMULATOR(ACCUMULATOR), .B_OPERAND(B_OPERAND), .STATUS_WORD(STATUS_WORD),
		.DATA_POINTER(DATA_POINTER), .XDATA_ADDR(XDATA_ADDR), .XDATA_EXT_SEL(XDATA_EXT_SEL),
		.XDATA_RDATA(XDATA_RDATA), .FLASH_WE(FLASH_WE));
	ext_mem_model EXT (.clk(CLK), .sel(XDATA_EXT_SEL), .we(XMOVE_WE), .fl_we(FLASH_WE), .n_wr_ff(n_wr), .n_fl_ff(n_fl));
	always #12.5 CLK = ~CLK;
	// whole run is about 130 cycles, so this ceiling only catches a hang
	always @(posedge CLK) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			n_fail = n_fail + 1;
			end_of_test;
		end
	end
	// ----
	// shared drivers
	// ----
	task end_of_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input [23:0] got, input [23:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick;
		@(negedge CLK);
	endtask
	// strobes drop one cycle before the next request is raised
	task rel;
		{PC_LOAD, PC_INC, INT_TAKE, PUSH, POP, IRAM_WE, IRAM_INDIRECT, IRAM_REG, BIT_WE, DP_INC, XMOVE} = 11'h000;
		{XMOVE_WE, XMOVE_VIA_DP} = 2'h0;
		ALU_OP = 3'h0;
		CODE_FETCH = 1'b1;
		// a buffer address left standing would read, and advance the pointer, every edge
		IRAM_ADDR = 8'h00;
		tick;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		IRAM_ADDR = a;
		IRAM_WDATA = d;
		IRAM_WE = 1'b1;
		tick;
		rel;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		IRAM_ADDR = a;
		tick;
		chk(IRAM_RDATA, e);
		rel;
	endtask
	task alu(input [2:0] op, input [7:0] src, input [23:0] e);
		ALU_OP = op;
		ALU_SRC = src;
		tick;
		chk({B_OPERAND, ACCUMULATOR, STATUS_WORD}, e);
		rel;
	endtask
	task xm(input w, input d);
		XMOVE = 1'b1;
		XMOVE_WE = w;
		XMOVE_VIA_DP = d;
		tick;
	endtask
	task bw(input [7:0] a);
		BIT_ADDR = a;
		BIT_WE = 1'b1;
		tick;
		rel;
	endtask
	// ----
	// scenarios
	// ----
	task t_flow;
		chk({PC, STACK_POINTER}, 16'h0007);
		chk(PC, 16'h0000);
		chk({ACCUMULATOR, B_OPERAND}, 16'h0000);
		chk(DATA_POINTER, 16'h0000);
		chk(STATUS_WORD, 8'h01);
		for (i = 0; i < 8; i = i + 1) begin
			INT_NUM = i[2:0];
			INT_TAKE = 1'b1;
			PC_LOAD = 1'b1;
			tick;
			chk(PC, 16'h0003 + 16'(i * 8));
			rel;
		end
		PC_VALUE = 16'h1234;
		PC_LOAD = 1'b1;
		tick;
		chk(PC, 16'h1234);
		PC_LOAD = 1'b0;
		PC_INC = 1'b1;
		tick;
		chk(PC, 16'h1235);
		rel;
		PUSH = 1'b1;
		PUSH_DATA = 8'hAA;
		tick;
		PUSH_DATA = 8'h55;
		tick;
		chk({STACK_POINTER, POP_DATA}, 16'h0955);
		rel;
		POP = 1'b1;
		tick;
		chk({STACK_POINTER, POP_DATA}, 16'h08AA);
		rel;
		rd(8'h08, 8'hAA);
		$display("flow test done");
	endtask
	task t_alu;
		alu(3'h3, 8'h7F, 24'h007F00);
		alu(3'h1, 8'h01, 24'h008044);
		alu(3'h1, 8'h81, 24'h000184);
		alu(3'h7, 8'h00, 24'h000180);
		alu(3'h6, 8'h40, 24'h000184);
		ALU_ROT_CARRY = 1'b1;
		alu(3'h3, 8'h10, 24'h001084);
		wr(8'hF0, 8'h20);
		alu(3'h4, 8'h00, 24'h020005);
		wr(8'hE0, 8'h07);
		alu(3'h5, 8'h00, 24'h010301);
		alu(3'h2, 8'h05, 24'h01FE00);
		alu(3'h2, 8'h01, 24'h01FDC0);
		wr(8'hE0, 8'h00);
		$display("alu test done");
	endtask
	task t_map;
		IRAM_INDIRECT = 1'b1;
		wr(8'hE0, 8'h33);
		chk(ACCUMULATOR, 8'h00);
		IRAM_INDIRECT = 1'b1;
		rd(8'hE0, 8'h33);
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'hD0, 8'(i * 8));
			IRAM_REG = 1'b1;
			IRAM_REGNUM = 3'h7;
			wr(8'h00, 8'(i + 8'hC0));
			rd(8'(i * 8 + 7), 8'(i + 8'hC0));
		end
		BIT_WDATA = 1'b1;
		bw(8'h7F);
		chk(BIT_RDATA, 1'b1);
		rd(8'h2F, 8'h80);
		bw(8'hE7);
		chk(ACCUMULATOR, 8'h80);
		$display("map test done");
	endtask
	task t_x;
		XMOVE_PTR8 = 8'h12;
		XMOVE_WDATA = 8'hA5;
		xm(1'b1, 1'b0);
		chk({XDATA_EXT_SEL, XDATA_ADDR[14:0]}, 16'h7F12);
		rel;
		wr(8'h83, 8'hFF);
		wr(8'h82, 8'h11);
		DP_INC = 1'b1;
		CODE_FETCH = 1'b0;
		tick;
		chk(CODE_ADDR, 16'hFF12);
		DP_INC = 1'b0;
		xm(1'b0, 1'b1);
		chk(XDATA_RDATA, 8'hA5);
		rel;
		wr(8'h95, 8'h05);
		wr(8'h96, 8'h77);
		rd(8'h95, 8'h06);
		rd(8'h96, 8'h77);
		rd(8'h95, 8'h07);
		XMOVE_PTR8 = 8'h05;
		xm(1'b0, 1'b0);
		chk(XDATA_RDATA, 8'h77);
		rel;
		wr(8'h83, 8'h12);
		xm(1'b1, 1'b1);
		chk(XDATA_EXT_SEL, 1'b1);
		rel;
		wr(8'h97, 8'h00);
		xm(1'b1, 1'b0);
		chk(XDATA_EXT_SEL, 1'b1);
		rel;
		chk(n_wr, 8'h02);
		FLASH_WE_REQ = 1'b1;
		tick;
		chk(FLASH_WE, 1'b0);
		FLASH_PROG = 1'b1;
		tick;
		chk(FLASH_WE, 1'b1);
		FLASH_WE_REQ = 1'b0;
		tick;
		chk(n_fl, 8'h01);
		$display("external test done");
	endtask
	initial begin
		{PC_VALUE, INT_NUM, IRAM_REGNUM, PUSH_DATA, IRAM_ADDR, IRAM_WDATA, BIT_ADDR, ALU_SRC, XMOVE_PTR8, XMOVE_WDATA} = 0;
		{RST_B, BIT_WDATA, ALU_CIN, ALU_ROT_CARRY, FLASH_WE_REQ, FLASH_PROG} = 6'h00;
		rel;
		repeat (10) tick;
		RST_B = 1'b1;
		t_flow;
		t_alu;
		t_map;
		t_x;
		end_of_test;
	end
endmodule // core_regs_tb
`default_nettype wire
